// ---- inc/wrt_pkg.sv ----
// Constants shared by the windowed refresh timer and its prescaler
`default_nettype none
package wrt_pkg;
    // ==========================================================
    // Counter layout
    localparam int          CNT_W        = 7;        // Downcounter width
    localparam int          EXPIRE_BIT   = 6;        // Counter expires when this bit falls
    localparam logic [6:0]  CNT_RESET    = 7'h7f;    // Counter value after reset
    localparam logic [6:0]  WIN_RESET    = 7'h7f;    // Window value after reset
    localparam logic [6:0]  CNT_EXPIRE   = 7'h40;    // Last value before expiry

    // ==========================================================
    // Tick timing at the 100 MHz system clock
    localparam int          CLK_PERIOD_NS = 10;      // System clock period
    localparam int          FAST_TICK_NS  = 75000;   // Shortest timeout step, 75 us
    localparam int          SLOW_TICK_NS  = 1000000; // Long step, 64 steps give 64 ms
    localparam int          FAST_TICK_CYC = FAST_TICK_NS / CLK_PERIOD_NS;
    localparam int          SLOW_TICK_CYC = SLOW_TICK_NS / CLK_PERIOD_NS;
    localparam int          TICK_CNT_W    = 20;      // Prescaler counter width
endpackage
`default_nettype wire

// ---- design/wrt_prescaler.sv ----
// Tick generator that divides the system clock for the downcounter
`timescale 1ns/1ps
`default_nettype none
module wrt_prescaler #(
    parameter int FAST_CYC = wrt_pkg::FAST_TICK_CYC, // Cycles per fast tick
    parameter int SLOW_CYC = wrt_pkg::SLOW_TICK_CYC  // Cycles per slow tick
) (
    input  wire logic sys_clk,   // System clock
    input  wire logic rst,       // Asynchronous reset, active high
    input  wire logic clk_en,    // Freezes all state while low
    input  wire logic restart,   // Restart the tick period
    input  wire logic slow_sel,  // Select the long tick period
    output logic      tick       // One-cycle tick pulse
);
    import wrt_pkg::*;

    localparam logic [TICK_CNT_W-1:0] FAST_LAST = TICK_CNT_W'(FAST_CYC - 1);
    localparam logic [TICK_CNT_W-1:0] SLOW_LAST = TICK_CNT_W'(SLOW_CYC - 1);

    logic [TICK_CNT_W-1:0] div_cnt;
    logic                  at_last;

    initial begin
        if (FAST_CYC < 1 || SLOW_CYC < 1 || SLOW_CYC >= (1 << TICK_CNT_W)
                || FAST_CYC >= (1 << TICK_CNT_W)) begin
            $error("wrt_prescaler: tick cycle counts out of range");
        end
    end

    assign at_last = slow_sel ? (div_cnt >= SLOW_LAST) : (div_cnt >= FAST_LAST);

    // ==========================================================
    // Divider counter and tick pulse
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            div_cnt <= '0;
            tick    <= 1'b0;
        end else if (clk_en) begin
            if (restart || at_last) begin
                div_cnt <= '0;
            end else begin
                div_cnt <= div_cnt + 1'b1;
            end
            tick <= at_last && !restart;
        end
    end
endmodule
`default_nettype wire

// ---- design/wrt_windowed_refresh_timer.sv ----
// Window watchdog: downcounter, window compare, activation and reset request
//
// Function
// - Activated by option setting caught at reset release, or by software enable.
// - Once active, nothing but a device reset makes it inactive.
// - Counter reaching expiry without refresh asserts reset; 75 us to 64 ms.
// - Refresh while counter is above window value asserts reset.
`timescale 1ns/1ps
`default_nettype none
module wrt_windowed_refresh_timer #(
    parameter int FAST_CYC = wrt_pkg::FAST_TICK_CYC, // Cycles per fast tick
    parameter int SLOW_CYC = wrt_pkg::SLOW_TICK_CYC  // Cycles per slow tick
) (
    input  wire logic                      sys_clk,     // System clock, 100 MHz
    input  wire logic                      rst,         // Asynchronous reset, active high
    input  wire logic                      clk_en,      // Freezes all state while low
    input  wire logic                      opt_enable,  // Option setting: active from reset
    input  wire logic                      sw_enable,   // Software activation strobe
    input  wire logic                      slow_sel,    // Long tick period select
    input  wire logic                      win_wr,      // Window value write strobe
    input  wire logic [wrt_pkg::CNT_W-1:0] win_val,     // New window value
    input  wire logic                      refresh,     // Refresh write strobe
    input  wire logic [wrt_pkg::CNT_W-1:0] refresh_val, // Value loaded by a refresh
    output logic                           active,      // Watchdog is running
    output logic [wrt_pkg::CNT_W-1:0]      count,       // Current downcounter value
    output logic [wrt_pkg::CNT_W-1:0]      window,      // Current window value
    output logic                           reset_req,   // Reset request, held until reset
    output logic                           early_fault  // Last reset was an early refresh
);
    import wrt_pkg::*;

    logic strap_done;
    logic tick;
    logic too_early;
    logic expire;

    initial begin
        if (CNT_W != EXPIRE_BIT + 1) begin
            $error("wrt_windowed_refresh_timer: counter width mismatch");
        end
    end

    // ==========================================================
    // Prescaler
    wrt_prescaler #(
        .FAST_CYC (FAST_CYC),
        .SLOW_CYC (SLOW_CYC)
    ) u_prescaler (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .clk_en   (clk_en),
        .restart  (refresh && active),
        .slow_sel (slow_sel),
        .tick     (tick)
    );

    // Fault conditions; a reload with the expiry bit clear expires at the next tick
    assign too_early = active && refresh && (count > window);
    assign expire    = active && tick && !refresh && (count <= CNT_EXPIRE);

    // ==========================================================
    // Activation: option setting caught once after reset release, software enable at any time
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            strap_done <= 1'b0;
            active     <= 1'b0;
        end else if (clk_en) begin
            strap_done <= 1'b1;
            if ((!strap_done && opt_enable) || sw_enable) begin
                active <= 1'b1;
            end
            // No clear path: only rst returns it to inactive
        end
    end

    // ==========================================================
    // Window register
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            window <= WIN_RESET;
        end else if (clk_en && win_wr) begin
            window <= win_val;
        end
    end

    // ==========================================================
    // Downcounter
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            count <= CNT_RESET;
        end else if (clk_en && active) begin
            if (refresh) begin
                count <= refresh_val;
            end else if (tick && count[EXPIRE_BIT]) begin
                count <= count - 1'b1;
            end
        end
    end

    // ==========================================================
    // Reset request, sticky until system reset
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reset_req   <= 1'b0;
            early_fault <= 1'b0;
        end else if (clk_en && !reset_req) begin
            if (too_early) begin
                reset_req   <= 1'b1;
                early_fault <= 1'b1;
            end else if (expire) begin
                reset_req   <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Assertions
    sequence s_refresh_ok;
        clk_en && active && refresh && (count <= window) && !reset_req;
    endsequence

    sequence s_early;
        clk_en && active && refresh && (count > window) && !reset_req;
    endsequence

    property p_enable;
        @(posedge sys_clk) disable iff (rst)
        (clk_en && sw_enable) |=> active;
    endproperty
    a_enable: assert property (p_enable) else $error("software enable did not activate");

    property p_opt;
        @(posedge sys_clk) disable iff (rst)
        (clk_en && !strap_done && opt_enable) |=> active;
    endproperty
    a_opt: assert property (p_opt) else $error("option setting did not activate");

    property p_sticky;
        @(posedge sys_clk) disable iff (rst)
        active |=> active [*4];
    endproperty
    a_sticky: assert property (p_sticky) else $error("watchdog left active state");

    property p_timeout;
        @(posedge sys_clk) disable iff (rst)
        (clk_en && active && tick && !refresh && count <= CNT_EXPIRE) |=> reset_req;
    endproperty
    a_timeout: assert property (p_timeout) else $error("expiry gave no reset");

    property p_no_spurious;
        @(posedge sys_clk) disable iff (rst)
        (!reset_req && !(clk_en && active)) |=> !reset_req;
    endproperty
    a_no_spurious: assert property (p_no_spurious) else $error("reset while inactive");

    property p_early;
        @(posedge sys_clk) disable iff (rst)
        s_early |=> (reset_req && early_fault) [*3];
    endproperty
    a_early: assert property (p_early) else $error("early refresh gave no reset");

    property p_reload;
        @(posedge sys_clk) disable iff (rst)
        s_refresh_ok |=> (count == $past(refresh_val)) && !early_fault;
    endproperty
    a_reload: assert property (p_reload) else $error("refresh did not reload");

    property p_decrement;
        @(posedge sys_clk) disable iff (rst)
        (clk_en && active && tick && !refresh && count[6]) |=> count == $past(count) - 7'h01;
    endproperty
    a_decrement: assert property (p_decrement) else $error("tick did not decrement");

    // Low enable freezes every register
    property p_frozen;
        @(posedge sys_clk) disable iff (rst)
        !clk_en |=> $stable(count) && $stable(window) && $stable(active) && $stable(reset_req);
    endproperty
    a_frozen: assert property (p_frozen) else $error("state moved while enable low");

    // Inactive counter holds still and a refresh is ignored
    property p_idle_hold;
        @(posedge sys_clk) disable iff (rst)
        (clk_en && !active) |=> $stable(count) && !reset_req;
    endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("inactive counter moved");

    // Window register takes the written value
    property p_window_wr;
        @(posedge sys_clk) disable iff (rst)
        (clk_en && win_wr) |=> window == $past(win_val);
    endproperty
    a_window_wr: assert property (p_window_wr) else $error("window write lost");

    // Option setting is looked at only once after reset
    property p_opt_once;
        @(posedge sys_clk) disable iff (rst)
        (clk_en && strap_done && !active && !sw_enable) |=> !active;
    endproperty
    a_opt_once: assert property (p_opt_once) else $error("late option activation");

    // Early flag only ever travels with a reset request
    property p_cause;
        @(posedge sys_clk) disable iff (rst)
        early_fault |-> reset_req;
    endproperty
    a_cause: assert property (p_cause) else $error("early flag without reset");

    // Request and its cause hold until system reset
    property p_fault_hold;
        @(posedge sys_clk) disable iff (rst)
        reset_req |=> reset_req && $stable(early_fault);
    endproperty
    a_fault_hold: assert property (p_fault_hold) else $error("reset request dropped");

    // Timeout alone leaves the early flag clear
    property p_timeout_cause;
        @(posedge sys_clk) disable iff (rst)
        (clk_en && !reset_req && expire) |=> reset_req && !early_fault;
    endproperty
    a_timeout_cause: assert property (p_timeout_cause) else $error("timeout marked early");
endmodule
`default_nettype wire

// ---- tb/wrt_tb.sv ----
// Self-checking testbench for the windowed refresh timer
`timescale 1ns/1ps
`default_nettype none
module tb;
    import wrt_pkg::*;
    // ==========================================================
    // Stimulus and observed signals
    localparam int FC = 4;              // Short fast tick for simulation
    localparam int SC = 10;             // Short slow tick for simulation
    logic             sys_clk     = 1'b0;
    logic             rst         = 1'b1;
    logic             clk_en      = 1'b1;
    logic             opt_enable  = 1'b0;
    logic             sw_enable   = 1'b0;
    logic             slow_sel    = 1'b0;
    logic             win_wr      = 1'b0;
    logic             refresh     = 1'b0;
    logic [CNT_W-1:0] win_val     = 7'h00;
    logic [CNT_W-1:0] refresh_val = 7'h00;
    logic             active;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] window;
    logic             reset_req;
    logic             early_fault;
    int               n_errors    = 0;
    int               n_checks    = 0;

    wrt_windowed_refresh_timer #(.FAST_CYC(FC), .SLOW_CYC(SC)) u_dut (
        .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .opt_enable(opt_enable),
        .sw_enable(sw_enable), .slow_sel(slow_sel), .win_wr(win_wr), .win_val(win_val),
        .refresh(refresh), .refresh_val(refresh_val), .active(active), .count(count),
        .window(window), .reset_req(reset_req), .early_fault(early_fault));

    // Clock at 100 MHz
    always #5 sys_clk = ~sys_clk;

    // ==========================================================
    // Shared tasks
    task end_sim;
        if (n_errors == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task chk_val(input logic [CNT_W-1:0] got, input logic [CNT_W-1:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task chk_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected flag at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // Reset held 10 cycles, then one edge so the option setting is caught
    task do_reset(input logic opt);
        opt_enable <= opt;
        rst        <= 1'b1;
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        #1;
    endtask

    // One-cycle request: refresh, window write and/or software enable
    task req(input logic r, input logic w, input logic e, input logic [CNT_W-1:0] v);
        @(posedge sys_clk);
        refresh     <= r;
        win_wr      <= w;
        sw_enable   <= e;
        refresh_val <= v;
        win_val     <= v;
        @(posedge sys_clk);
        refresh   <= 1'b0;
        win_wr    <= 1'b0;
        sw_enable <= 1'b0;
        #1;
    endtask

    // ==========================================================
    // Scenarios
    task t_reset_and_idle;
        do_reset(1'b0);
        chk_bit(active, 1'b0);
        chk_val(count, 7'h7f);
        chk_val(window, 7'h7f);
        chk_bit(reset_req, 1'b0);
        req(1'b1, 1'b0, 1'b0, 7'h50);
        chk_val(count, 7'h7f);
        chk_bit(reset_req, 1'b0);
    endtask

    task t_option_start;
        do_reset(1'b1);
        chk_bit(active, 1'b1);
        do_reset(1'b0);
        chk_bit(active, 1'b0);
    endtask

    // Software start, valid refresh, then a refresh above the window
    task t_early_refresh;
        do_reset(1'b0);
        req(1'b0, 1'b0, 1'b1, 7'h00);
        chk_bit(active, 1'b1);
        req(1'b1, 1'b0, 1'b0, 7'h7f);
        chk_val(count, 7'h7f);
        chk_bit(reset_req, 1'b0);
        req(1'b0, 1'b1, 1'b0, 7'h45);
        chk_val(window, 7'h45);
        req(1'b1, 1'b0, 1'b0, 7'h60);
        chk_bit(reset_req, 1'b1);
        chk_bit(early_fault, 1'b1);
        repeat (20) @(posedge sys_clk);
        #1;
        chk_bit(active, 1'b1);
        chk_bit(reset_req, 1'b1);
    endtask

    // Keep alive inside the window, then let the counter expire
    task t_timeout(input logic s);
        int n;
        int per;
        per = s ? SC : FC;
        do_reset(1'b0);
        slow_sel <= s;
        req(1'b0, 1'b0, 1'b1, 7'h00);
        for (int i = 0; i < 10; i++) begin
            req(1'b1, 1'b0, 1'b0, 7'h41);
            repeat (per - 1) @(posedge sys_clk);
        end
        #1;
        chk_bit(reset_req, 1'b0);
        req(1'b1, 1'b0, 1'b0, 7'h41);
        chk_val(count, 7'h41);
        for (n = 0; n < 100 && reset_req !== 1'b1; n++) begin
            @(posedge sys_clk);
            #1;
        end
        chk_bit((n >= 2 * per - 1) && (n <= 2 * per + 4), 1'b1);
        chk_val(count, CNT_EXPIRE - 7'h01);
        chk_bit(early_fault, 1'b0);
        slow_sel <= 1'b0;
    endtask

    // Equal-window refresh, frozen enable, then a reload below expiry
    task t_freeze_window;
        do_reset(1'b0);
        req(1'b0, 1'b0, 1'b1, 7'h00);
        req(1'b1, 1'b0, 1'b0, 7'h50);
        chk_val(count, 7'h50);
        req(1'b0, 1'b1, 1'b0, 7'h50);
        req(1'b1, 1'b0, 1'b0, 7'h50);
        chk_bit(reset_req, 1'b0);
        @(posedge sys_clk);
        clk_en <= 1'b0;
        repeat (2 * FC) @(posedge sys_clk);
        req(1'b1, 1'b0, 1'b0, 7'h7f);
        chk_val(count, 7'h50);
        @(posedge sys_clk);
        clk_en <= 1'b1;
        req(1'b1, 1'b0, 1'b0, 7'h30);
        chk_val(count, 7'h30);
        repeat (FC + 1) @(posedge sys_clk);
        #1;
        chk_bit(reset_req, 1'b1);
        chk_bit(early_fault, 1'b0);
    endtask

    // ==========================================================
    // Main sequence and watchdog
    initial begin
        t_reset_and_idle();
        t_option_start();
        t_early_refresh();
        t_timeout(1'b0);
        t_timeout(1'b1);
        t_freeze_window();
        end_sim();
    end

    initial begin
        repeat (5000) @(posedge sys_clk);
        n_errors++;
        end_sim();
    end
endmodule
`default_nettype wire
